/* File: wfd_frame_source.sv */
// Remote station model that plays one stored frame into the receive port
`timescale 1ns/1ps
module wfd_frame_source (
  input  wire logic             ref_clk,
  output wfd_pkg::wfd_rx_beat_t rx_beat,
  output wfd_pkg::wfd_rx_end_t  rx_end
);
  import wfd_pkg::*;
  logic [7:0] mem [0:255];
  initial begin
    rx_beat = '0;
    rx_end  = '0;
  end
  task automatic send(input int len, input logic fcs, input logic lok);
    for (int i = 0; i < len; i++) begin
      @(posedge ref_clk);
      rx_beat <= '{valid: 1'b1, sof: (i == 0), data: mem[i]};
    end
    @(posedge ref_clk);
    // Released line shows inverted data beside the verdict
    rx_beat <= '{valid: 1'b0, sof: 1'b0, data: ~rx_beat.data};
    rx_end  <= '{done: 1'b1, fcs_ok: fcs, len_ok: lok};
    @(posedge ref_clk);
    rx_end  <= '0;
  endtask
endmodule

/* File: wfd_pkg.sv */
// Shared constants and types of the wake frame detector
package wfd_pkg;
  // Register byte offsets
  localparam logic [7:0] WFD_OFS_WAKE_CONTROL_STATUS  = 8'h00;
  localparam logic [7:0] WFD_OFS_FILTER_CONFIG        = 8'h04;
  localparam logic [7:0] WFD_OFS_FILTER_CHECKSUM      = 8'h08;
  localparam logic [7:0] WFD_OFS_BYTE_SELECT_0        = 8'h0c;
  localparam logic [7:0] WFD_OFS_BYTE_SELECT_1        = 8'h10;
  localparam logic [7:0] WFD_OFS_BYTE_SELECT_2        = 8'h14;
  localparam logic [7:0] WFD_OFS_BYTE_SELECT_3        = 8'h18;
  localparam logic [7:0] WFD_OFS_STATION_WORD_A       = 8'h1c;
  localparam logic [7:0] WFD_OFS_STATION_WORD_B       = 8'h20;
  localparam logic [7:0] WFD_OFS_STATION_WORD_C       = 8'h24;
  localparam logic [7:0] WFD_OFS_PORT_IRQ_MASK        = 8'h28;
  localparam logic [7:0] WFD_OFS_PORT_IRQ_SOURCE      = 8'h2c;

  // Field positions
  localparam int WFD_BIT_MAGIC_ENABLE    = 1;
  localparam int WFD_BIT_PATTERN_ENABLE  = 2;
  localparam int WFD_BIT_MAGIC_SEEN      = 5;
  localparam int WFD_BIT_PATTERN_SEEN    = 6;
  localparam int WFD_BIT_FILTER_TRIGGER  = 24;
  localparam int WFD_BIT_ADDR_MATCH_EN   = 28;
  localparam int WFD_BIT_ANY_MCAST_EN    = 29;
  localparam int WFD_BIT_BCAST_EN        = 30;
  localparam int WFD_BIT_FILTER_EN       = 31;
  localparam int WFD_BIT_WOL_EVENT       = 8;

  // Reset and start values
  localparam logic [31:0] WFD_RST_WORD   = 32'h0000_0000;
  localparam logic [15:0] WFD_CRC_INIT   = 16'h0fff;

  // Frame layout and search figures
  localparam logic [10:0] WFD_ADDR_FIELDS_END = 11'h00c;
  localparam logic [10:0] WFD_POS_MAX         = 11'h7ff;
  localparam logic [2:0]  WFD_SYNC_LEN        = 3'h6;
  localparam logic [2:0]  WFD_ADDR_LAST_BYTE  = 3'h5;
  localparam logic [3:0]  WFD_COPIES_LAST     = 4'hf;
  localparam logic [10:0] WFD_MASK_SPAN       = 11'h080;
  localparam logic [7:0]  WFD_ALL_ONES_BYTE   = 8'hff;

  // One received byte of a frame
  typedef struct packed {
    logic       valid;
    logic       sof;
    logic [7:0] data;
  } wfd_rx_beat_t;

  // End-of-frame verdict from the receive path
  typedef struct packed {
    logic done;
    logic fcs_ok;
    logic len_ok;
  } wfd_rx_end_t;

  typedef enum logic [1:0] {
    WFD_SYNC_HUNT   = 2'b01,
    WFD_ADDR_COPIES = 2'b10
  } wfd_magic_state_t;
endpackage

/* File: wfd_wake_frame_detector.sv */
// Wake frame detector: magic packet and pattern filter wake events
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps

// Functional notes
// - Magic candidate only when destination is station address or broadcast.
// - Six all-ones bytes then sixteen unbroken station address copies mean magic.
// - Broken copy sequence restarts the hunt for a new all-ones run.
// - Sync run and copies may sit anywhere after the address fields, copies directly after sync.
// - Wake flags only for frames passing FCS and length checks.
// - Magic match sets interrupt source bit 8 and magic seen flag.
// - Mask bit j selects frame byte at offset plus j for CRC.
// - CRC-16 of selected bytes compared with expected value at end.
// - Accumulator starts at the start value, updates on selected bytes only.
// - Intermediates F0..F7 chain accumulator high bits with data bits.
// - Next accumulator formed from low bits and intermediates per fixed map.
// - Offset positions count from first destination byte as zero.
// - Address matching accepts only programmed address; mcast, bcast separately enabled.
// - Specific, any-multicast and broadcast results are ORed.
// - Wake needs filter enabled, CRC match and frame-type address condition.
// - Pattern wake sets pattern seen flag and filter triggered flag.
// - Software reset leaves all wake registers untouched.
module wfd_wake_frame_detector (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  soft_reset,
  input  wire wfd_pkg::wfd_rx_beat_t rx_beat,
  input  wire wfd_pkg::wfd_rx_end_t  rx_end,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic [31:0]                reg_rdata,
  output logic                       wake_event
);
  import wfd_pkg::*;

  logic [31:0]      wake_control_status;
  logic [31:0]      filter_config_primary;
  logic [15:0]      filter_expected_checksum;
  logic [127:0]     filter_byte_select;
  logic [15:0]      station_address_word_a;
  logic [15:0]      station_address_word_b;
  logic [15:0]      station_address_word_c;
  logic [31:0]      port_irq_mask;
  logic [31:0]      port_irq_source;
  logic [10:0]      pos_count;
  logic [10:0]      cur_pos;
  logic [10:0]      rel_pos;
  logic             pos_in_window;
  logic             byte_selected;
  logic [15:0]      crc;
  logic [15:0]      crc_base;
  logic [47:0]      station;
  logic [7:0]       station_byte;
  logic             da_station_hit;
  logic             da_bcast;
  logic             da_mcast;
  logic [2:0]       ff_run;
  logic [2:0]       copy_byte;
  logic [3:0]       copy_count;
  logic             magic_hit;
  wfd_magic_state_t magic_state;
  logic             frame_good;
  logic             magic_ok;
  logic             addr_qual;
  logic             pattern_ok;
  logic             extra_sync;
  logic             copy_match;
  logic             wr_status;
  logic             wr_config;
  logic             wr_source;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [7:0]  f;
    logic [15:0] n;
    f    = 8'h00;
    n    = 16'h0000;
    f[0] = c[15] ^ d[0];
    for (int i = 1; i < 8; i++) begin
      f[i] = c[15-i] ^ f[i-1] ^ d[i];
    end
    n[15]    = c[7] ^ f[7];
    n[14:10] = c[6:2];
    n[9]     = c[1] ^ f[0];
    n[8]     = c[0] ^ f[1];
    for (int k = 0; k < 6; k++) begin
      n[7-k] = f[k] ^ f[k+2];
    end
    n[1]     = f[6];
    n[0]     = f[7];
    return n;
  endfunction

  assign station   = {station_address_word_c, station_address_word_b, station_address_word_a};
  assign wr_status = reg_write && (reg_addr == WFD_OFS_WAKE_CONTROL_STATUS);
  assign wr_config = reg_write && (reg_addr == WFD_OFS_FILTER_CONFIG);
  assign wr_source = reg_write && (reg_addr == WFD_OFS_PORT_IRQ_SOURCE);

  assign cur_pos       = rx_beat.sof ? 11'h000 : pos_count;
  assign rel_pos       = cur_pos - {3'h0, filter_config_primary[7:0]};
  assign pos_in_window = (cur_pos >= {3'h0, filter_config_primary[7:0]}) && (rel_pos < WFD_MASK_SPAN);
  assign byte_selected = rx_beat.valid && pos_in_window && filter_byte_select[rel_pos[6:0]];
  assign crc_base      = rx_beat.sof ? WFD_CRC_INIT : crc;

  // Byte position within the frame, saturating on long frames
  always_ff @(posedge ref_clk) begin
    if (reset || soft_reset) begin
      pos_count <= 11'h000;
    end else if (rx_beat.valid) begin
      pos_count <= (cur_pos == WFD_POS_MAX) ? WFD_POS_MAX : cur_pos + 11'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || soft_reset) begin
      crc <= WFD_CRC_INIT;
    end else if (byte_selected) begin
      crc <= crc_step(crc_base, rx_beat.data);
    end else if (rx_beat.valid && rx_beat.sof) begin
      crc <= WFD_CRC_INIT;
    end
  end

  // Destination address classification
  always_ff @(posedge ref_clk) begin
    if (reset || soft_reset) begin
      da_station_hit <= 1'b0;
      da_bcast       <= 1'b0;
      da_mcast       <= 1'b0;
    end else if (rx_beat.valid && cur_pos < 11'h006) begin
      if (rx_beat.sof) begin
        da_station_hit <= (rx_beat.data == station[7:0]);
        da_bcast       <= (rx_beat.data == WFD_ALL_ONES_BYTE);
        da_mcast       <= rx_beat.data[0];
      end else begin
        da_station_hit <= da_station_hit && (rx_beat.data == station[8*cur_pos[2:0] +: 8]);
        da_bcast       <= da_bcast && (rx_beat.data == WFD_ALL_ONES_BYTE);
      end
    end
  end

  assign station_byte = station[8*copy_byte +: 8];
  assign copy_match   = (rx_beat.data == station_byte);
  assign extra_sync   = (copy_byte == 3'h0) && (copy_count == 4'h0) &&
                        (rx_beat.data == WFD_ALL_ONES_BYTE) && !copy_match;

  always_ff @(posedge ref_clk) begin
    if (reset || soft_reset) begin
      magic_state <= WFD_SYNC_HUNT;
      ff_run      <= 3'h0;
      copy_byte   <= 3'h0;
      copy_count  <= 4'h0;
      magic_hit   <= 1'b0;
    end else if (rx_beat.valid && rx_beat.sof) begin
      magic_state <= WFD_SYNC_HUNT;
      ff_run      <= 3'h0;
      copy_byte   <= 3'h0;
      copy_count  <= 4'h0;
      magic_hit   <= 1'b0;
    end else if (rx_beat.valid && cur_pos >= WFD_ADDR_FIELDS_END && !magic_hit) begin
      case (magic_state)
        WFD_SYNC_HUNT: begin
          copy_byte  <= 3'h0;
          copy_count <= 4'h0;
          if (rx_beat.data == WFD_ALL_ONES_BYTE) begin
            if (ff_run == WFD_SYNC_LEN - 3'h1) begin
              magic_state <= WFD_ADDR_COPIES;
            end
            ff_run <= ff_run + 3'h1;
          end else begin
            ff_run <= 3'h0;
          end
        end
        WFD_ADDR_COPIES: begin
          if (copy_match) begin
            if (copy_byte == WFD_ADDR_LAST_BYTE) begin
              copy_byte <= 3'h0;
              if (copy_count == WFD_COPIES_LAST) begin
                magic_hit <= 1'b1;
              end
              copy_count <= copy_count + 4'h1;
            end else begin
              copy_byte <= copy_byte + 3'h1;
            end
          end else if (!extra_sync) begin
            magic_state <= WFD_SYNC_HUNT;
            copy_byte   <= 3'h0;
            copy_count  <= 4'h0;
            ff_run      <= (rx_beat.data == WFD_ALL_ONES_BYTE) ? 3'h1 : 3'h0;
          end
        end
        default: begin
          magic_state <= WFD_SYNC_HUNT;
          ff_run      <= 3'h0;
        end
      endcase
    end
  end

  assign frame_good = rx_end.done && rx_end.fcs_ok && rx_end.len_ok;
  assign magic_ok   = frame_good && magic_hit && wake_control_status[WFD_BIT_MAGIC_ENABLE] &&
                      (da_station_hit || da_bcast);
  assign addr_qual  = da_station_hit ||
                      (da_mcast && !da_bcast && filter_config_primary[WFD_BIT_ANY_MCAST_EN]) ||
                      (da_bcast && filter_config_primary[WFD_BIT_BCAST_EN]);

  // specific address only when matching on
  always_comb begin
    pattern_ok = 1'b0;
    if (da_bcast) begin
      pattern_ok = filter_config_primary[WFD_BIT_BCAST_EN];
    end else if (da_mcast) begin
      pattern_ok = addr_qual;
    end else begin
      pattern_ok = !filter_config_primary[WFD_BIT_ADDR_MATCH_EN] || addr_qual;
    end
    pattern_ok = pattern_ok && frame_good && filter_config_primary[WFD_BIT_FILTER_EN] &&
                 wake_control_status[WFD_BIT_PATTERN_ENABLE] && (crc == filter_expected_checksum);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wake_control_status <= WFD_RST_WORD;
    end else begin
      if (wr_status) begin
        wake_control_status[WFD_BIT_MAGIC_ENABLE]   <= reg_wdata[WFD_BIT_MAGIC_ENABLE];
        wake_control_status[WFD_BIT_PATTERN_ENABLE] <= reg_wdata[WFD_BIT_PATTERN_ENABLE];
      end
      wake_control_status[WFD_BIT_MAGIC_SEEN] <= magic_ok ||
        (wake_control_status[WFD_BIT_MAGIC_SEEN] && !(wr_status && reg_wdata[WFD_BIT_MAGIC_SEEN]));
      wake_control_status[WFD_BIT_PATTERN_SEEN] <= pattern_ok ||
        (wake_control_status[WFD_BIT_PATTERN_SEEN] && !(wr_status && reg_wdata[WFD_BIT_PATTERN_SEEN]));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      filter_config_primary <= WFD_RST_WORD;
    end else begin
      if (wr_config) begin
        filter_config_primary[7:0]   <= reg_wdata[7:0];
        filter_config_primary[31:28] <= reg_wdata[31:28];
      end
      filter_config_primary[WFD_BIT_FILTER_TRIGGER] <= pattern_ok ||
        (filter_config_primary[WFD_BIT_FILTER_TRIGGER] && !(wr_config && reg_wdata[WFD_BIT_FILTER_TRIGGER]));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      filter_expected_checksum <= WFD_RST_WORD[15:0];
      filter_byte_select       <= {4{WFD_RST_WORD}};
      station_address_word_a   <= WFD_RST_WORD[15:0];
      station_address_word_b   <= WFD_RST_WORD[15:0];
      station_address_word_c   <= WFD_RST_WORD[15:0];
      port_irq_mask            <= WFD_RST_WORD;
    end else if (reg_write) begin
      case (reg_addr)
        WFD_OFS_FILTER_CHECKSUM: filter_expected_checksum  <= reg_wdata[15:0];
        WFD_OFS_BYTE_SELECT_0:   filter_byte_select[31:0]   <= reg_wdata;
        WFD_OFS_BYTE_SELECT_1:   filter_byte_select[63:32]  <= reg_wdata;
        WFD_OFS_BYTE_SELECT_2:   filter_byte_select[95:64]  <= reg_wdata;
        WFD_OFS_BYTE_SELECT_3:   filter_byte_select[127:96] <= reg_wdata;
        WFD_OFS_STATION_WORD_A:  station_address_word_a    <= reg_wdata[15:0];
        WFD_OFS_STATION_WORD_B:  station_address_word_b    <= reg_wdata[15:0];
        WFD_OFS_STATION_WORD_C:  station_address_word_c    <= reg_wdata[15:0];
        WFD_OFS_PORT_IRQ_MASK:   port_irq_mask[WFD_BIT_WOL_EVENT] <= reg_wdata[WFD_BIT_WOL_EVENT];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_irq_source <= WFD_RST_WORD;
    end else begin
      port_irq_source[WFD_BIT_WOL_EVENT] <= magic_ok || pattern_ok ||
        (port_irq_source[WFD_BIT_WOL_EVENT] && !(wr_source && reg_wdata[WFD_BIT_WOL_EVENT]));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= port_irq_source[WFD_BIT_WOL_EVENT] && port_irq_mask[WFD_BIT_WOL_EVENT];
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= WFD_RST_WORD;
    end else if (reg_read) begin
      case (reg_addr)
        WFD_OFS_WAKE_CONTROL_STATUS: reg_rdata <= wake_control_status;
        WFD_OFS_FILTER_CONFIG:       reg_rdata <= filter_config_primary;
        WFD_OFS_FILTER_CHECKSUM:     reg_rdata <= {16'h0000, filter_expected_checksum};
        WFD_OFS_BYTE_SELECT_0:       reg_rdata <= filter_byte_select[31:0];
        WFD_OFS_BYTE_SELECT_1:       reg_rdata <= filter_byte_select[63:32];
        WFD_OFS_BYTE_SELECT_2:       reg_rdata <= filter_byte_select[95:64];
        WFD_OFS_BYTE_SELECT_3:       reg_rdata <= filter_byte_select[127:96];
        WFD_OFS_STATION_WORD_A:      reg_rdata <= {16'h0000, station_address_word_a};
        WFD_OFS_STATION_WORD_B:      reg_rdata <= {16'h0000, station_address_word_b};
        WFD_OFS_STATION_WORD_C:      reg_rdata <= {16'h0000, station_address_word_c};
        WFD_OFS_PORT_IRQ_MASK:       reg_rdata <= port_irq_mask;
        WFD_OFS_PORT_IRQ_SOURCE:     reg_rdata <= port_irq_source;
        default:                     reg_rdata <= WFD_RST_WORD;
      endcase
    end else begin
      reg_rdata <= WFD_RST_WORD;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_good_end;
    rx_end.done && rx_end.fcs_ok && rx_end.len_ok;
  endsequence

  sequence s_magic_end;
    s_good_end ##0 (magic_hit && wake_control_status[WFD_BIT_MAGIC_ENABLE] && (da_station_hit || da_bcast));
  endsequence

  property p_magic_flag;
    s_magic_end |=> wake_control_status[WFD_BIT_MAGIC_SEEN] && port_irq_source[WFD_BIT_WOL_EVENT];
  endproperty
  a_magic_flag: assert property (p_magic_flag) else $error("magic match did not set flags");

  property p_magic_needs_addr;
    (rx_end.done && !da_station_hit && !da_bcast && !wake_control_status[WFD_BIT_MAGIC_SEEN] && !soft_reset)
      |=> !wake_control_status[WFD_BIT_MAGIC_SEEN];
  endproperty
  a_magic_needs_addr: assert property (p_magic_needs_addr) else $error("magic flag without address hit");

  property p_bad_frame_quiet;
    (rx_end.done && !(rx_end.fcs_ok && rx_end.len_ok) && !port_irq_source[WFD_BIT_WOL_EVENT])
      |=> !port_irq_source[WFD_BIT_WOL_EVENT];
  endproperty
  a_bad_frame_quiet: assert property (p_bad_frame_quiet) else $error("wake on failed frame");

  property p_copy_break;
    (magic_state == WFD_ADDR_COPIES && rx_beat.valid && !rx_beat.sof && !magic_hit &&
     !copy_match && !extra_sync && !soft_reset) |=> magic_state == WFD_SYNC_HUNT && copy_count == 4'h0;
  endproperty
  a_copy_break: assert property (p_copy_break) else $error("broken copies did not restart hunt");

  property p_crc_hold;
    (!byte_selected && !(rx_beat.valid && rx_beat.sof) && !soft_reset) |=> $stable(crc);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc moved on unselected byte");

  property p_crc_step;
    (byte_selected && !soft_reset) |=> crc[14:10] == $past(crc_base[6:2]) &&
      crc[7] == (^{$past(crc_base[14:13]), $past(rx_beat.data[2:1])}) &&
      crc[0] == (crc[1] ^ $past(crc_base[8]) ^ $past(rx_beat.data[7]));
  endproperty
  a_crc_step: assert property (p_crc_step) else $error("crc update wrong");

  property p_pattern_flags;
    (s_good_end ##0 pattern_ok) |=> wake_control_status[WFD_BIT_PATTERN_SEEN] &&
      filter_config_primary[WFD_BIT_FILTER_TRIGGER];
  endproperty
  a_pattern_flags: assert property (p_pattern_flags) else $error("pattern wake flags not set");

  property p_pattern_crc;
    (rx_end.done && !(filter_config_primary[WFD_BIT_FILTER_EN] && crc == filter_expected_checksum) &&
     !wake_control_status[WFD_BIT_PATTERN_SEEN]) |=> !wake_control_status[WFD_BIT_PATTERN_SEEN];
  endproperty
  a_pattern_crc: assert property (p_pattern_crc) else $error("pattern wake without crc match");

  property p_soft_keep;
    (soft_reset && !reg_write && !rx_end.done) |=> $stable(wake_control_status) && $stable(filter_config_primary);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset changed wake registers");

  property p_wake_out;
    (port_irq_source[WFD_BIT_WOL_EVENT] && port_irq_mask[WFD_BIT_WOL_EVENT]) |=> wake_event;
  endproperty
  a_wake_out: assert property (p_wake_out) else $error("wake output missing");
endmodule

/* File: wfd_wake_frame_detector_test.sv */
// Self-checking bench for the wake frame detector
`timescale 1ns/1ps
module wfd_wake_frame_detector_test;
  import wfd_pkg::*;
  logic         ref_clk;
  logic         reset;
  logic         soft_reset;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata;
  logic         reg_write;
  logic         reg_read;
  logic [31:0]  reg_rdata;
  logic         wake_event;
  wfd_rx_beat_t rx_beat;
  wfd_rx_end_t  rx_end;
  int           err_total = 0;
  int           samples_checked = 0;
  int           cycles = 0;
  int           n;
  logic [31:0]  en_word;
  logic [31:0]  cur_cfg;
  logic [7:0]   sta [6] = '{8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
  int           pc [9] = '{0, 1, 1, 0, 2, 0, 4, 0, 0};
  int           pk [9] = '{0, 0, 1, 2, 2, 3, 3, 0, 0};
  int           pb [9] = '{0, 0, 0, 0, 0, 0, 0, 1, 2};
  logic         pe [9] = '{1, 0, 1, 0, 1, 0, 1, 0, 0};
  int           sel [3] = '{0, 3, 10};

  wfd_wake_frame_detector dut (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .soft_reset (soft_reset),
    .rx_beat    (rx_beat),
    .rx_end     (rx_end),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_write  (reg_write),
    .reg_read   (reg_read),
    .reg_rdata  (reg_rdata),
    .wake_event (wake_event)
  );
  wfd_frame_source src (
    .ref_clk (ref_clk),
    .rx_beat (rx_beat),
    .rx_end  (rx_end)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic put(input logic [7:0] b);
    src.mem[n] = b;
    n++;
  endtask
  task automatic sync_copies(input int c);
    for (int i = 0; i < 6; i++) put(8'hff);
    for (int k = 0; k < c * 6; k++) put(sta[k % 6]);
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [7:0]  f;
    logic [15:0] r;
    f[0] = c[15] ^ d[0];
    for (int i = 1; i < 8; i++) f[i] = c[15 - i] ^ f[i - 1] ^ d[i];
    r[15] = c[7] ^ f[7];
    r[14:10] = c[6:2];
    r[9] = c[1] ^ f[0];
    r[8] = c[0] ^ f[1];
    for (int k = 0; k < 6; k++) r[7 - k] = f[k] ^ f[k + 2];
    r[1] = f[6];
    r[0] = f[7];
    return r;
  endfunction

  task automatic judge(input string name, input logic mg, input logic pt);
    logic [31:0] d;
    rd(WFD_OFS_WAKE_CONTROL_STATUS, d);
    chk("status", d, en_word | (32'(mg) << WFD_BIT_MAGIC_SEEN) | (32'(pt) << WFD_BIT_PATTERN_SEEN));
    rd(WFD_OFS_FILTER_CONFIG, d);
    chk("filter_config", d, cur_cfg | (32'(pt) << WFD_BIT_FILTER_TRIGGER));
    rd(WFD_OFS_PORT_IRQ_SOURCE, d);
    chk("irq_source", d, 32'(mg | pt) << WFD_BIT_WOL_EVENT);
    chk("wake_event", 32'(wake_event), 32'(mg | pt));
    wr(WFD_OFS_WAKE_CONTROL_STATUS, en_word | 32'h60);
    wr(WFD_OFS_FILTER_CONFIG, cur_cfg | 32'h0100_0000);
    wr(WFD_OFS_PORT_IRQ_SOURCE, 32'h100);
    repeat (2) @(posedge ref_clk);
    #1 chk("wake_event cleared", 32'(wake_event), 32'h0);
    $display("test %s done", name);
  endtask

  task automatic run_m(input string name, input int kind, input int pre, input int c1, input int c2,
                       input logic fcs, input logic lok, input logic mg);
    n = 0;
    for (int i = 0; i < 6; i++) put(kind == 0 ? sta[i] : kind == 1 ? 8'hff : 8'h40 + 8'(i));
    // Source address, then optional filler before the sync run
    for (int i = 0; i < 6 + pre; i++) put(8'h0a);
    sync_copies(c1);
    if (c2 > 0) begin
      put(8'h77);
      sync_copies(c2);
    end
    for (int i = 0; i < 4; i++) put(8'h00);
    src.send(n, fcs, lok);
    judge(name, mg, 1'b0);
  endtask

  task automatic run_p(input int k);
    logic [15:0] c;
    n = 0;
    for (int i = 0; i < 6; i++)
      put(pk[k] == 1 ? sta[i] : pk[k] == 3 ? 8'hff : (pk[k] == 2 && i == 0) ? 8'h01 : 8'h40 + 8'(i));
    for (int i = 6; i < 52; i++) put(8'(i * 7 + 3));
    c = 16'h0fff;
    foreach (sel[j]) c = crc_step(c, src.mem[2 + sel[j]]);
    cur_cfg = 32'h8000_0002 | (32'(pc[k]) << 28);
    wr(WFD_OFS_FILTER_CONFIG, cur_cfg & 32'h7fff_ffff);
    wr(WFD_OFS_FILTER_CHECKSUM, {16'h0, c ^ 16'(pb[k] == 1)});
    wr(WFD_OFS_FILTER_CONFIG, cur_cfg);
    if (k == 0) begin
      en_word = en_word | (32'h1 << WFD_BIT_PATTERN_ENABLE);
      wr(WFD_OFS_WAKE_CONTROL_STATUS, en_word);
    end
    src.send(52, 1'b1, pb[k] != 2);
    judge($sformatf("pattern %0d", k), 1'b0, pe[k]);
  endtask

  initial begin
    logic [31:0] d;
    reset = 1'b1;
    soft_reset = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    cur_cfg = 32'h0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    for (int a = 0; a <= 'h30; a += 4) begin
      rd(8'(a), d);
      chk("reset value", d, 32'h0);
    end
    wr(8'h30, 32'hffff_ffff);
    rd(8'h30, d);
    chk("unmapped", d, 32'h0);
    $display("test registers done");
    wr(WFD_OFS_STATION_WORD_A, 32'h1100);
    wr(WFD_OFS_STATION_WORD_B, 32'h3322);
    wr(WFD_OFS_STATION_WORD_C, 32'h5544);
    en_word = 32'h1 << WFD_BIT_MAGIC_ENABLE;
    wr(WFD_OFS_WAKE_CONTROL_STATUS, en_word);
    wr(WFD_OFS_PORT_IRQ_MASK, 32'h100);
    run_m("magic station", 0, 0, 16, 0, 1, 1, 1);
    run_m("magic bcast late", 1, 5, 16, 0, 1, 1, 1);
    run_m("magic other da", 2, 0, 16, 0, 1, 1, 0);
    run_m("magic short", 0, 0, 15, 0, 1, 1, 0);
    run_m("magic restart", 0, 0, 15, 16, 1, 1, 1);
    run_m("magic bad fcs", 0, 0, 16, 0, 0, 1, 0);
    run_m("magic bad len", 0, 0, 16, 0, 1, 0, 0);
    wr(WFD_OFS_BYTE_SELECT_0, 32'h0000_0409);
    wr(WFD_OFS_BYTE_SELECT_3, 32'h0100_0000);
    for (int k = 0; k < 9; k++) run_p(k);
    @(posedge ref_clk);
    soft_reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    soft_reset <= 1'b0;
    rd(WFD_OFS_STATION_WORD_A, d);
    chk("station after soft reset", d, 32'h1100);
    rd(WFD_OFS_FILTER_CONFIG, d);
    chk("config after soft reset", d, cur_cfg);
    run_m("magic after soft reset", 1, 0, 16, 0, 1, 1, 1);
    end_of_test();
  end
endmodule
